// ### card_deact_model.sv
`timescale 1ns/1ps
`default_nettype none
module card_deact_model (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       req,
   input wire logic [7:0] delay,
   output logic           done
);
   logic [7:0] cnt_q;
   // The card is released only after a chosen delay, so slow cards hold the entry back.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
         done  <= 1'b0;
      end else if (!req) begin
         cnt_q <= 8'h00;
         done  <= 1'b0;
      end else if (cnt_q >= delay) begin
         done <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule // card_deact_model
`default_nettype wire

// ### power_mode_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module power_mode_checker
   import power_mode_pkg::*;
(
   input wire logic                  hclk,
   input wire logic                  hresetn,
   input wire logic                  hreadyout,
   input wire logic                  hresp,
   input wire logic                  reset_pin_n,
   input wire logic                  main_supply_ok,
   input wire logic                  host_busy,
   input wire logic                  usb_activity,
   input wire logic                  card_deact_req,
   input wire logic [1:0]            pad_supply_regulator_mode,
   input wire logic                  transmitter_supply_regulator_en,
   input wire logic                  main_regulator_lowpower,
   input wire logic                  low_freq_oscillator_en,
   input wire logic                  main_clock_en,
   input wire logic                  retained_clk_sel_slow,
   input wire logic [num_periph-1:0] periph_clk_en,
   input wire logic                  usb_idle_event,
   input wire logic [1:0]            power_state
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence pin_low_s;
      !reset_pin_n [*4];
   endsequence
   // An entry is only legal after the card deactivation handshake was under way.
   sequence entry_s;
      $past(power_state) == st_active ##0 power_state inside {st_standby, st_suspend};
   endsequence

   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   pin_hpd_a: assert property (pin_low_s |=> power_state == st_hpd)
      else $error("reset pin low did not force power-down");
   hpd_off_a: assert property (power_state == st_hpd |-> !main_clock_en &&
      !low_freq_oscillator_en && main_regulator_lowpower && !transmitter_supply_regulator_en
      && pad_supply_regulator_mode == pad_off) else $error("power-down left a supply running");
   hpd_exit_a: assert property ($past(power_state) == st_hpd && power_state != st_hpd |->
      $past(reset_pin_n, 3) && $past(main_supply_ok, 3)) else $error("early power-down exit");
   suspend_clk_a: assert property (power_state == st_suspend |-> !main_clock_en &&
      low_freq_oscillator_en && periph_clk_en == '0) else $error("clock running in suspend");
   suspend_pad_a: assert property (power_state == st_suspend |->
      pad_supply_regulator_mode inside {pad_lowpower, pad_off}) else $error("pad mode wrong");
   standby_clk_a: assert property (power_state == st_standby |-> retained_clk_sel_slow &&
      main_regulator_lowpower && periph_clk_en == '0) else $error("standby clocking wrong");
   entry_deact_a: assert property (entry_s |-> $past(card_deact_req))
      else $error("low-power entry without card deactivation");
   busy_block_a: assert property ((host_busy && power_state == st_active) [*4] |=>
      power_state inside {st_active, st_hpd}) else $error("entry while host busy");
   usb_idle_a: assert property (usb_activity [*4] |-> !$rose(usb_idle_event))
      else $error("idle event during bus activity");
endmodule // power_mode_checker

bind power_mode_controller power_mode_checker u_chk (.hclk, .hresetn, .hreadyout, .hresp,
   .reset_pin_n, .main_supply_ok, .host_busy, .usb_activity, .card_deact_req,
   .pad_supply_regulator_mode, .transmitter_supply_regulator_en, .main_regulator_lowpower,
   .low_freq_oscillator_en, .main_clock_en, .retained_clk_sel_slow, .periph_clk_en,
   .usb_idle_event, .power_state);
`default_nettype wire

// ### power_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller
   import power_mode_pkg::*;
(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   input  wire logic                  reset_pin_n,
   input  wire logic                  main_supply_ok,
   input  wire logic                  pad_regulator_output_grounded,
   input  wire logic                  pad_supply_present,
   input  wire logic                  host_busy,
   input  wire logic                  usb_activity,
   input  wire logic                  field_detector_enabled,
   input  wire logic [num_wake-2:0]   wake_in,
   input  wire logic                  temp1_below_limit,
   input  wire logic                  temp2_below_limit,
   input  wire logic                  card_deact_done,
   output logic                       card_deact_req,
   output logic [1:0]                 pad_supply_regulator_mode,
   output logic                       transmitter_supply_regulator_en,
   output logic [2:0]                 transmitter_supply_regulator_level,
   output logic                       main_regulator_lowpower,
   output logic                       low_freq_oscillator_en,
   output logic                       main_clock_en,
   output logic                       retained_clk_sel_slow,
   output logic [3:0]                 sys_clk_div,
   output logic [3:0]                 per_clk_div,
   output logic [num_periph-1:0]      periph_clk_en,
   output logic                       usb_idle_event,
   output logic [1:0]                 power_state
);

   typedef struct packed {
      logic [31:0]         ctrl;
      logic [31:0]         wake_en;
      logic [31:0]         clk_cfg;
      logic [2:0]          evt;
      logic                dph_valid;
      logic                dph_write;
      logic [7:0]          dph_addr;
      logic [31:0]         rdata;
      pwr_state_t          state;
      pwr_state_t          target;
      logic                deact;
      logic                oheat;
      logic [31:0]         idle_cnt;
      logic [num_wake-1:0] wake_q;
      logic [num_wake+9:0] s1;
      logic [num_wake+9:0] s2;
   } state_t;

   state_t st_q;
   state_t st_d;

   logic [10:0]            raw_in;
   logic [num_wake-1:0]    wake_vec;
   logic                   rst_pin_s;
   logic                   main_supply_input_ok_s;
   logic                   pad_gnd_s;
   logic                   pad_pres_s;
   logic                   host_busy_s;
   logic                   usb_act_s;
   logic                   fd_en_s;
   logic                   t1_s;
   logic                   t2_s;
   logic                   deact_done_s;
   logic                   wake_hit;
   logic                   blocked;
   logic                   hpd_cond;
   logic                   addr_phase;
   logic [2:0]             evt_set;

   assign raw_in = {card_deact_done, temp2_below_limit, temp1_below_limit,
                    field_detector_enabled, usb_activity, host_busy, pad_supply_present,
                    pad_regulator_output_grounded, main_supply_ok, reset_pin_n, 1'b0};
   // Only the second synchroniser stage is used; stage one feeds stage two alone.
   assign rst_pin_s    = st_q.s2[1];
   assign main_supply_input_ok_s    = st_q.s2[2];
   assign pad_gnd_s    = st_q.s2[3];
   assign pad_pres_s   = st_q.s2[4];
   assign host_busy_s  = st_q.s2[5];
   assign usb_act_s    = st_q.s2[6];
   assign fd_en_s      = st_q.s2[7];
   assign t1_s         = st_q.s2[8];
   assign t2_s         = st_q.s2[9];
   assign deact_done_s = st_q.s2[10];

   genvar gi;
   generate
      for (gi = 0; gi < num_wake - 1; gi++) begin : g_wake
         assign wake_vec[gi] = st_q.s2[11+gi] & st_q.wake_en[gi];
      end
   endgenerate
   assign wake_vec[wk_temp] = st_q.oheat & t1_s & t2_s & st_q.wake_en[wk_temp];

   assign wake_hit = |wake_vec;
   // Field detector selected as wake source but powered off also blocks entry.
   assign blocked  = host_busy_s | wake_hit | (st_q.wake_en[wk_field] & ~fd_en_s)
                     | ~pad_pres_s;
   assign hpd_cond = ~rst_pin_s | (~main_supply_input_ok_s & st_q.ctrl[ctrl_auto_hpd_bit]);
   assign addr_phase = hsel & hready & htrans[1];

   always_comb begin
      st_d = st_q;
      evt_set = 3'b000;
      st_d.s1 = {wake_in, raw_in};
      st_d.s2 = st_q.s1;
      st_d.wake_q = wake_vec;

      // USB idle counter; saturates so the event fires once per idle period.
      if (usb_act_s || st_q.state != st_active) begin
         st_d.idle_cnt = 32'h0000_0000;
      end else if (st_q.idle_cnt < 32'(usb_idle_cycles)) begin
         st_d.idle_cnt = st_q.idle_cnt + 32'h0000_0001;
         if (st_d.idle_cnt == 32'(usb_idle_cycles)) begin
            evt_set[0] = 1'b1;
         end
      end

      // AHB-Lite data phase.
      st_d.dph_valid = addr_phase;
      st_d.dph_write = hwrite;
      st_d.dph_addr  = haddr[7:0];
      if (!addr_phase) begin
         st_d.dph_write = 1'b0;
      end
      st_d.rdata = 32'h0000_0000;
      if (addr_phase && !hwrite) begin
         unique case (haddr[7:0])
            ctrl_off:    st_d.rdata = st_q.ctrl;
            wake_en_off: st_d.rdata = st_q.wake_en;
            clk_cfg_off: st_d.rdata = st_q.clk_cfg;
            status_off:  st_d.rdata = {16'h0000, st_q.wake_q, st_q.deact, st_q.oheat,
                                       st_q.state, blocked, pad_gnd_s};
            event_off:   st_d.rdata = {29'h0000_0000, st_q.evt};
            default:     st_d.rdata = 32'h0000_0000;
         endcase
      end
      if (st_q.dph_valid && st_q.dph_write) begin
         unique case (st_q.dph_addr)
            ctrl_off:    st_d.ctrl    = hwdata;
            wake_en_off: st_d.wake_en = hwdata;
            clk_cfg_off: st_d.clk_cfg = hwdata;
            event_off:   st_d.evt     = st_q.evt & ~hwdata[2:0];
            default:     st_d.ctrl    = st_q.ctrl;
         endcase
      end

      // Power state machine.
      if (hpd_cond) begin
         st_d.state = st_hpd;
         st_d.deact = 1'b0;
      end else begin
         unique case (st_q.state)
            st_hpd: begin
               if (rst_pin_s && main_supply_input_ok_s) begin
                  st_d.state = st_active;
               end
            end
            st_active: begin
               if (st_q.deact) begin
                  if (blocked) begin
                     st_d.deact = 1'b0;
                     evt_set[1] = 1'b1;
                  end else if (deact_done_s) begin
                     st_d.deact = 1'b0;
                     st_d.state = st_q.target;
                  end
               end else if (st_d.ctrl[ctrl_standby_bit] || st_d.ctrl[ctrl_suspend_bit]) begin
                  st_d.ctrl[ctrl_standby_bit] = 1'b0;
                  st_d.ctrl[ctrl_suspend_bit] = 1'b0;
                  st_d.target = st_d.ctrl[ctrl_standby_bit] ? st_standby : st_suspend;
                  st_d.target = st_q.dph_write && hwdata[ctrl_standby_bit]
                                ? st_standby : st_suspend;
                  // Overheat flag lets the temperature wake source be armed.
                  st_d.oheat = st_d.ctrl[ctrl_overheat_bit];
                  if (blocked) begin
                     evt_set[1] = 1'b1;
                  end else begin
                     st_d.deact = 1'b1;
                  end
               end
            end
            st_standby, st_suspend: begin
               if (wake_hit) begin
                  st_d.state = st_active;
                  st_d.oheat = 1'b0;
                  evt_set[2] = 1'b1;
               end
            end
            default: st_d.state = st_active;
         endcase
      end
      // Hardware set wins over a software clear in the same cycle.
      st_d.evt = st_d.evt | evt_set;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '{ctrl: ctrl_reset, wake_en: wake_en_reset, clk_cfg: clk_cfg_reset,
                   state: st_active, target: st_standby, default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   assign hrdata    = st_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_comb begin
      pad_supply_regulator_mode = pad_active;
      if (pad_gnd_s || st_q.state == st_hpd) begin
         pad_supply_regulator_mode = pad_off;
      end else if (st_q.state == st_standby) begin
         pad_supply_regulator_mode = st_q.ctrl[ctrl_pad_sb_lsb +: 2];
      end else if (st_q.state == st_suspend) begin
         pad_supply_regulator_mode = pad_lowpower;
      end
   end

   assign transmitter_supply_regulator_en = st_q.ctrl[ctrl_tx_en_bit]
                                            & (st_q.state == st_active);
   assign transmitter_supply_regulator_level = st_q.ctrl[ctrl_tx_lvl_lsb +: 3];
   assign main_regulator_lowpower = st_q.state != st_active;
   assign low_freq_oscillator_en  = st_q.state != st_hpd;
   assign main_clock_en           = st_q.state == st_active;
   assign retained_clk_sel_slow   = st_q.state != st_active;
   assign sys_clk_div   = st_q.clk_cfg[clk_sys_div_lsb +: 4];
   assign per_clk_div   = st_q.clk_cfg[clk_per_div_lsb +: 4];
   assign periph_clk_en = (st_q.state == st_active)
                          ? st_q.clk_cfg[clk_per_en_lsb +: num_periph] : '0;
   assign card_deact_req = st_q.deact;
   assign usb_idle_event = st_q.evt[0];
   assign power_state    = st_q.state;

endmodule // power_mode_controller
`default_nettype wire

// ### power_mode_pkg.sv
package power_mode_pkg;

   // Register byte offsets on the AHB-Lite slave.
   localparam logic [7:0] ctrl_off    = 8'h00;
   localparam logic [7:0] wake_en_off = 8'h04;
   localparam logic [7:0] clk_cfg_off = 8'h08;
   localparam logic [7:0] status_off  = 8'h0C;
   localparam logic [7:0] event_off   = 8'h10;

   // Control register fields.
   localparam int ctrl_standby_bit  = 0;
   localparam int ctrl_suspend_bit  = 1;
   localparam int ctrl_auto_hpd_bit = 2;
   localparam int ctrl_overheat_bit = 3;
   localparam int ctrl_pad_sb_lsb   = 4;
   localparam int ctrl_tx_lvl_lsb   = 8;
   localparam int ctrl_tx_en_bit    = 11;

   // Clock configuration register fields.
   localparam int clk_sys_div_lsb   = 0;
   localparam int clk_per_div_lsb   = 4;
   localparam int clk_per_en_lsb    = 8;
   localparam int num_periph        = 16;

   // Pad-supply regulator modes.
   typedef enum logic [1:0] {
      pad_active   = 2'b00,
      pad_lowpower = 2'b01,
      pad_off      = 2'b10
   } pad_mode_t;

   // Transmitter regulator output levels.
   typedef enum logic [2:0] {
      tx_3v00 = 3'b000,
      tx_3v30 = 3'b001,
      tx_3v60 = 3'b010,
      tx_4v50 = 3'b011,
      tx_4v75 = 3'b100
   } tx_level_t;

   typedef enum logic [1:0] {
      st_active  = 2'b00,
      st_standby = 2'b01,
      st_suspend = 2'b10,
      st_hpd     = 2'b11
   } pwr_state_t;

   localparam int num_wake = 10;
   // Wake source indices.
   localparam int wk_host     = 0;
   localparam int wk_field    = 1;
   localparam int wk_gpio     = 2;
   localparam int wk_card_in  = 3;
   localparam int wk_card_out = 4;
   localparam int wk_aux_uart = 5;
   localparam int wk_counter  = 6;
   localparam int wk_pad_oc   = 7;
   localparam int wk_tx_ovv   = 8;
   localparam int wk_temp     = 9;

   localparam logic [31:0] ctrl_reset    = 32'h0000_0010;
   localparam logic [31:0] wake_en_reset = 32'h0000_0000;
   localparam logic [31:0] clk_cfg_reset = 32'h0000_FF00;

   // USB idle time before the suspend-request event.
   localparam int usb_idle_us     = 3000;
   localparam int clk_mhz         = 100;
   localparam int usb_idle_cycles = usb_idle_us * clk_mhz + 1;

endpackage

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import power_mode_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, reset_pin_n = 1, main_supply_ok = 1;
   logic pad_regulator_output_grounded = 0, pad_supply_present = 1, host_busy = 0;
   logic usb_activity = 1, field_detector_enabled = 1, temp1_below_limit = 1;
   logic temp2_below_limit = 1, card_deact_done, hreadyout, hresp, card_deact_req;
   logic transmitter_supply_regulator_en, main_regulator_lowpower, low_freq_oscillator_en;
   logic main_clock_en, retained_clk_sel_slow, usb_idle_event;
   logic [31:0]           haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]            htrans = 0, pad_supply_regulator_mode, power_state;
   logic [num_wake-2:0]   wake_in = '0;
   logic [7:0]            delay = 8'h00;
   logic [2:0]            transmitter_supply_regulator_level;
   logic [3:0]            sys_clk_div, per_clk_div;
   logic [num_periph-1:0] periph_clk_en;
   int err_count = 0, total_checks = 0;

   always #5 hclk = ~hclk;

   power_mode_controller u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .reset_pin_n,
      .main_supply_ok, .pad_regulator_output_grounded, .pad_supply_present, .host_busy,
      .usb_activity, .field_detector_enabled, .wake_in, .temp1_below_limit,
      .temp2_below_limit, .card_deact_done, .card_deact_req, .pad_supply_regulator_mode,
      .transmitter_supply_regulator_en, .transmitter_supply_regulator_level,
      .main_regulator_lowpower, .low_freq_oscillator_en, .main_clock_en,
      .retained_clk_sel_slow, .sys_clk_div, .per_clk_div, .periph_clk_en, .usb_idle_event,
      .power_state);
   card_deact_model u_card (.clk(hclk), .rst_n(hresetn), .req(card_deact_req), .delay,
      .done(card_deact_done));

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Bus handshake waits are unbounded; the 200 us watchdog guards them and the whole test.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      // Let the write settle so that outputs compared next show the new register value.
      #1;
   endtask
   task automatic wait_st(input pwr_state_t s);
      for (int n = 0; n < 300 && power_state !== s; n++) @(posedge hclk);
      chk(32'(power_state), 32'(s));
   endtask
   task automatic set_cond(input int c, input logic v);
      case (c)
         0: host_busy <= v;
         1: wake_in[wk_gpio] <= v;
         2: field_detector_enabled <= !v;
         default: pad_supply_present <= !v;
      endcase
   endtask

   initial begin
      #200_000;
      err_count++;
      conclude();
   end

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      wait_st(st_active);
      bus(0, ctrl_off, 0); chk(rd, ctrl_reset);
      bus(0, wake_en_off, 0); chk(rd, wake_en_reset);
      bus(0, clk_cfg_off, 0); chk(rd, clk_cfg_reset);
      bus(1, 8'h20, 32'hFFFF_FFFF); bus(0, 8'h20, 0); chk(rd, 32'h0);
      bus(1, clk_cfg_off, 32'h00A5_C369);
      chk({8'h0, periph_clk_en, per_clk_div, sys_clk_div}, 32'h00A5_C369);
      for (int i = 0; i < 5; i++) begin
         bus(1, ctrl_off, 32'h0810 | 32'(i << 8));
         chk({28'h0, transmitter_supply_regulator_en, transmitter_supply_regulator_level},
            32'h8 | 32'(i));
      end
      bus(1, ctrl_off, 32'h0410); chk(32'(transmitter_supply_regulator_en), 32'h0);
      bus(1, wake_en_off, 32'h6);
      for (int i = 0; i < 8; i++) begin
         set_cond(i % 4, 1'b1); repeat (4) @(posedge hclk);
         bus(1, ctrl_off, (i < 4) ? 32'h11 : 32'h12); repeat (8) @(posedge hclk);
         chk({power_state, card_deact_req}, 3'b000);
         bus(1, ctrl_off, 32'h10); bus(0, event_off, 0);
         chk(rd & 32'h2, 32'h2);
         bus(1, event_off, 32'h2); set_cond(i % 4, 1'b0); repeat (4) @(posedge hclk);
      end
      for (int i = 0; i < 3; i++) begin
         delay <= 8'(i * 30);
         bus(1, ctrl_off, 32'h1 | 32'(i << 4)); wait_st(st_standby);
         bus(1, ctrl_off, 32'(i << 4)); chk(32'(pad_supply_regulator_mode), 32'(i));
         chk({retained_clk_sel_slow, main_regulator_lowpower}, 2'b11);
         wake_in[wk_card_in] <= 1'b1; repeat (8) @(posedge hclk);
         chk(32'(power_state), 32'(st_standby));
         wake_in <= 9'h004; wait_st(st_active);
         wake_in <= '0; repeat (4) @(posedge hclk);
      end
      bus(1, wake_en_off, 32'h40); bus(1, ctrl_off, 32'h12); wait_st(st_suspend);
      chk(32'(pad_supply_regulator_mode), 32'(pad_lowpower));
      chk({main_clock_en, low_freq_oscillator_en, periph_clk_en}, 18'h10000);
      wake_in <= 9'h040; wait_st(st_active);
      wake_in <= '0; temp1_below_limit <= 0; temp2_below_limit <= 0;
      bus(1, wake_en_off, 32'h200); bus(1, ctrl_off, 32'h19); wait_st(st_standby);
      bus(1, ctrl_off, 32'h18); temp1_below_limit <= 1; repeat (8) @(posedge hclk);
      chk(32'(power_state), 32'(st_standby));
      temp2_below_limit <= 1; wait_st(st_active);
      pad_regulator_output_grounded <= 1; repeat (4) @(posedge hclk);
      chk(32'(pad_supply_regulator_mode), 32'(pad_off));
      bus(0, status_off, 0); chk(rd & 32'h1, 32'h1);
      pad_regulator_output_grounded <= 0;
      bus(1, ctrl_off, 32'h14); main_supply_ok <= 0; wait_st(st_hpd);
      chk({main_clock_en, low_freq_oscillator_en, main_regulator_lowpower}, 3'b001);
      main_supply_ok <= 1; wait_st(st_active);
      bus(1, ctrl_off, 32'h10); main_supply_ok <= 0; repeat (10) @(posedge hclk);
      chk(32'(power_state), 32'(st_active));
      reset_pin_n <= 0; wait_st(st_hpd);
      reset_pin_n <= 1; repeat (10) @(posedge hclk);
      chk(32'(power_state), 32'(st_hpd));
      main_supply_ok <= 1; wait_st(st_active);
      chk(32'(usb_idle_event), 32'h0);
      conclude();
   end
endmodule // testbench
`default_nettype wire
